// file: testbench/tb_top.sv
// Self-checking bench of the receive buffer and status block.
// Assumes reads answer one cycle after the strobe and a short bit time.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import usrbs_pkg::*;
  localparam int BC = 4; // Short bit time keeps the run brief
  logic       clk, resetn, regWr, regRd, rxLine, rxPinOwned, rxIrq;
  logic [1:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic [8:0] word;
  logic [3:0] nBits;
  logic       go, parEn, parOdd, parFlip, stopLow, busy;
  logic       rdSeen = 1'b0; // Read strobe seen at the last edge
  logic [7:0] expQ[$];   // Expected read data, oldest first
  logic [7:0] d[5];      // Characters of the overrun scenario
  logic [31:0] rnd = 32'h0000_d0e4;
  int         n_fail = 0;
  int         comparisons = 0;

  usrbs_receiver #(.BIT_CYCLES(BC)) dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxPin(rxLine),
    .rxPinOwned(rxPinOwned), .rxIrq(rxIrq));
  usrbs_tx_model #(.BIT_CYCLES(BC)) txPeer (.clk(clk), .go(go), .word(word), .nBits(nBits),
    .parEn(parEn), .parOdd(parOdd), .parFlip(parFlip), .stopLow(stopLow), .txLine(rxLine), .busy(busy));

  // Free running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic fail(input string m);
    n_fail++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask

  task automatic cmp1(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp) fail(m);
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watcher: read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rdSeen) begin
      if (expQ.size() == 0) fail("read data without expectation");
      else cmp8(regRdata, expQ.pop_front());
    end
    rdSeen <= regRd;
  end

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
  endtask

  // Let the updates of the last edge land before looking at flags
  task automatic settle;
    @(posedge clk);
    #1;
  endtask

  // Frame format register and the matching transmitter setup
  task automatic setc(input logic [7:0] v);
    wr(ADDR_CTRL_C, v);
    nBits  <= (v[2:0] == CSIZE_NINE) ? 4'd9 : 4'd5 + {2'b00, v[1:0]};
    parEn  <= v[CC_PAR_EN];
    parOdd <= v[CC_PAR_ODD];
  endtask

  task automatic launch(input logic [8:0] w, input logic pf, input logic sl);
    @(posedge clk);
    word    <= w;
    parFlip <= pf;
    stopLow <= sl;
    go      <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask

  // Wait for the frame end, then the stated settling of the buffer stage
  task automatic finish;
    for (int i = 0; i < 200 && busy; i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask

  task automatic send(input logic [8:0] w, input logic pf, input logic sl);
    launch(w, pf, sl);
    finish();
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    #300_000;
    fail("watchdog expired");
    report_and_stop();
  end

  initial begin
    {resetn, regWr, regRd, regAddr, regWdata, go, word, parEn, parOdd, parFlip, stopLow} = '0;
    nBits = 4'd8;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_CTRL_B, CTRL_B_RST);
    rd(ADDR_CTRL_C, CTRL_C_RST);
    rd(ADDR_DATA, 8'h00);
    settle();
    cmp1(rxPinOwned, 1'b0, "pin owned after reset");
    // Traffic while disabled must leave no entry
    send(9'h055, 1'b0, 1'b0);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_CTRL_B, 8'h90);
    settle();
    cmp1(rxPinOwned, 1'b1, "pin not taken");
    // Character sizes five to eight, upper bits masked
    for (int c = 0; c < 4; c++) begin
      setc(8'(c));
      rnd = lfsr(rnd);
      send(rnd[8:0], 1'b0, 1'b0);
      settle();
      cmp1(rxIrq, 1'b1, "irq missing");
      rd(ADDR_STATUS, 8'h80);
      rd(ADDR_DATA, rnd[7:0] & (8'hff >> (3 - c)));
      settle();
      cmp1(rxIrq, 1'b0, "irq stuck");
    end
    // Framing fault with the two-stop setting, then a clean frame
    setc(8'h0b);
    send(9'h03c, 1'b0, 1'b1);
    send(9'h0c3, 1'b0, 1'b0);
    wr(ADDR_CTRL_B, 8'h10);
    settle();
    cmp1(rxIrq, 1'b0, "irq while masked");
    wr(ADDR_CTRL_B, 8'h90);
    rd(ADDR_STATUS, 8'h90);
    // Zeros at the flag positions; the set frame flag must survive
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_DATA, 8'h00);
    rd(ADDR_STATUS, 8'h90);
    rd(ADDR_DATA, 8'h3c);
    rd(ADDR_STATUS, 8'h80);
    rd(ADDR_DATA, 8'hc3);
    // Even and odd checking, good and bad parity bit
    for (int p = 0; p < 4; p++) begin
      setc(p[1] ? 8'h33 : 8'h23);
      rnd = lfsr(rnd);
      send(rnd[8:0], p[0], 1'b0);
      rd(ADDR_STATUS, p[0] ? 8'h84 : 8'h80);
      rd(ADDR_DATA, rnd[7:0]);
    end
    // Bad parity stored, then checking switched off before the read
    send(9'h011, 1'b1, 1'b0);
    setc(8'h03);
    rd(ADDR_STATUS, 8'h80);
    rd(ADDR_DATA, 8'h11);
    // Nine-bit mode: ninth bit and status before data
    setc(8'h07);
    send(9'h1a5, 1'b0, 1'b0);
    send(9'h05a, 1'b0, 1'b0);
    rd(ADDR_CTRL_B, 8'h92);
    rd(ADDR_STATUS, 8'h80);
    rd(ADDR_DATA, 8'ha5);
    rd(ADDR_CTRL_B, 8'h90);
    rd(ADDR_DATA, 8'h5a);
    // Four frames back to back: two buffered, one held, one lost
    setc(8'h03);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      d[k] = rnd[7:0];
      send(rnd[8:0], 1'b0, 1'b0);
    end
    rd(ADDR_STATUS, 8'h80);
    rd(ADDR_DATA, d[0]);
    rd(ADDR_STATUS, 8'h80);
    rd(ADDR_DATA, d[1]);
    rd(ADDR_STATUS, 8'h88);
    rd(ADDR_DATA, d[2]);
    rd(ADDR_STATUS, 8'h00);
    send(9'h066, 1'b0, 1'b0);
    rd(ADDR_STATUS, 8'h80);
    // Flush by reading until the buffer reports empty
    send(9'h077, 1'b0, 1'b0);
    rd(ADDR_DATA, 8'h66);
    rd(ADDR_DATA, 8'h77);
    rd(ADDR_STATUS, 8'h00);
    // Disable flushes two entries and frees the pin
    send(9'h001, 1'b0, 1'b0);
    send(9'h002, 1'b0, 1'b0);
    wr(ADDR_CTRL_B, 8'h00);
    settle();
    cmp1(rxIrq, 1'b0, "irq after flush");
    cmp1(rxPinOwned, 1'b0, "pin still taken");
    rd(ADDR_STATUS, 8'h00);
    // Disable in mid-frame drops the reception at once
    wr(ADDR_CTRL_B, 8'h90);
    launch(9'h0ff, 1'b0, 1'b0);
    repeat (2 * BC) @(posedge clk);
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_CTRL_B, 8'h90);
    finish();
    rd(ADDR_STATUS, 8'h00);
    // Second reset with an entry present
    send(9'h0aa, 1'b0, 1'b0);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_CTRL_B, CTRL_B_RST);
    settle();
    cmp1(rxIrq, 1'b0, "irq after reset");
    cmp1(rxPinOwned, 1'b0, "pin owned after second reset");
    repeat (2) @(posedge clk);
    if (expQ.size() != 0) fail("reads left unanswered");
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: testbench/usrbs_tx_model.sv
// Behavioural remote transmitter that drives the serial receive line.
// Assumes the bench pulses go for one cycle only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module usrbs_tx_model #(
  parameter int BIT_CYCLES = 4
) (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [8:0] word,
  input  wire logic [3:0] nBits,
  input  wire logic       parEn,
  input  wire logic       parOdd,
  input  wire logic       parFlip,
  input  wire logic       stopLow,
  output logic            txLine,
  output logic            busy
);
  logic [8:0] w; // Character trimmed to the frame size

  // Hold one bit on the line for one full bit time
  task automatic send_bit(input logic b);
    txLine <= b;
    repeat (BIT_CYCLES) @(posedge clk);
  endtask

  // Line idles high, as a real transmitter leaves it
  initial begin
    txLine = 1'b1;
    busy   = 1'b0;
  end

  // One frame per go pulse: start, data LSB first, parity, a single stop bit
  always @(posedge clk) begin
    if (go) begin
      busy <= 1'b1;
      w = word & ((9'h001 << nBits) - 9'h001);
      send_bit(1'b0);
      for (int i = 0; i < nBits; i++) begin
        send_bit(w[i]);
      end
      // Flip only when a scenario asks for a bad parity bit
      if (parEn) begin
        send_bit(^w ^ parOdd ^ parFlip);
      end
      // Low stop bit only on request, to provoke a framing fault
      send_bit(~stopLow);
      txLine <= 1'b1;
      busy   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verilog/usrbs_frame_rx.sv
// Serial frame shifter: finds a start bit, samples each bit at its middle.
// Assumes a synchronised, idle-high line and static settings during a frame.
`timescale 1ns/1ps
`default_nettype none
module usrbs_frame_rx
  import usrbs_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clear,
  input  wire logic       rxLine,
  input  wire logic [3:0] numBits,
  input  wire logic       parityEn,
  input  wire logic       parityOdd,
  output logic            startSeen,
  output logic            frameDone,
  output logic [8:0]      frameData,
  output logic            stopBad,
  output logic            parityBad
);
  initial if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) $error("BIT_CYCLES out of range");
  typedef enum {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} usrbs_rxst_e;
  usrbs_rxst_e st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;     // Cycles into the current bit
  logic [3:0]  idx_reg, idx_next;     // Data bit index
  logic [8:0]  dat_reg, dat_next;     // Bits gathered so far
  logic        par_reg, par_next;     // Received parity bit
  logic        done_next, bad_next, pbad_next, start_next;
  logic        bad_reg, pbad_reg, start_reg, done_reg;
  localparam logic [15:0] HALF = 16'((BIT_CYCLES - 1) / 2);
  localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
  // Next state: one sample per bit at its middle; only the first stop bit counts
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg + 16'h0001;
    idx_next = idx_reg;
    dat_next = dat_reg;
    par_next = par_reg;
    done_next = 1'b0;
    start_next = 1'b0;
    bad_next = bad_reg;
    pbad_next = pbad_reg;
    case (st_reg)
      S_IDLE: begin
        cnt_next = 16'h0000;
        if (!rxLine) begin
          st_next = S_START;
        end
      end
      S_START: begin
        if (cnt_reg == HALF) begin
          cnt_next = 16'h0000;
          idx_next = 4'h0;
          dat_next = 9'h000;
          // A high middle sample is only a spike
          st_next = rxLine ? S_IDLE : S_DATA;
          start_next = !rxLine;
        end
      end
      S_DATA: begin
        if (cnt_reg == FULL) begin
          cnt_next = 16'h0000;
          dat_next[idx_reg] = rxLine;
          idx_next = idx_reg + 4'h1;
          if (idx_reg == numBits - 4'h1) begin
            st_next = parityEn ? S_PAR : S_STOP;
          end
        end
      end
      S_PAR: begin
        if (cnt_reg == FULL) begin
          cnt_next = 16'h0000;
          par_next = rxLine;
          st_next = S_STOP;
        end
      end
      S_STOP: begin
        if (cnt_reg == FULL) begin
          // Frame ends on the first stop bit, whatever the stop count
          st_next = S_IDLE;
          done_next = 1'b1;
          bad_next = !rxLine;
          pbad_next = parityEn && ((^dat_reg) ^ par_reg ^ parityOdd);
        end
      end
      default: st_next = S_IDLE;
    endcase
    if (clear) begin
      st_next = S_IDLE;
      done_next = 1'b0;
      start_next = 1'b0;
    end
  end
  // Registers only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= S_IDLE;
      cnt_reg <= 16'h0000;
      idx_reg <= 4'h0;
      dat_reg <= 9'h000;
      par_reg <= 1'b0;
      bad_reg <= 1'b0;
      pbad_reg <= 1'b0;
      done_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      dat_reg <= dat_next;
      par_reg <= par_next;
      bad_reg <= bad_next;
      pbad_reg <= pbad_next;
      done_reg <= done_next;
      start_reg <= start_next;
    end
  end
  assign startSeen = start_reg;
  assign frameDone = done_reg;
  assign frameData = dat_reg;
  assign stopBad = bad_reg;
  assign parityBad = pbad_reg;
endmodule
`default_nettype wire

// file: verilog/usrbs_pkg.sv
// Shared constants of the serial receive buffer and status block.
// Assumes an 8-bit register port and one 125 MHz system clock.
package usrbs_pkg;
  // Register offsets on the register port
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_CTRL_B = 2'h1;
  localparam logic [1:0] ADDR_CTRL_C = 2'h2;
  localparam logic [1:0] ADDR_DATA   = 2'h3;
  // Status register bit positions
  localparam int ST_RX_DONE = 7;
  localparam int ST_FRM_ERR = 4;
  localparam int ST_OVR     = 3;
  localparam int ST_PAR_ERR = 2;
  // Control register B bit positions
  localparam int CB_IRQ_EN = 7;
  localparam int CB_RX_ON  = 4;
  localparam int CB_RX9    = 1;
  // Control register C bit positions
  localparam int CC_PAR_EN  = 5;
  localparam int CC_PAR_ODD = 4;
  localparam int CC_STOPS   = 3;
  localparam int CC_CSIZE   = 0;
  // Character size code selecting nine data bits
  localparam logic [2:0] CSIZE_NINE = 3'h7;
  // Reset values of the control registers
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CTRL_C_RST = 8'h06;
  // Buffer entry layout: nine data bits plus three error bits
  localparam int ENT_W   = 12;
  localparam int ENT_FRM_ERR = 9;
  localparam int ENT_OVR     = 10;
  localparam int ENT_PAR_ERR = 11;
  // System clock cycles per serial bit, default only
  localparam int BIT_CYCLES_DEF = 16;
  // Buffer depth in characters
  localparam int FIFO_DEPTH = 2;
endpackage

// file: verilog/usrbs_receiver.sv
// Receive buffer and status block of a serial port: two-entry buffer,
// error flags stored per character, register port and receive interrupt.
// Assumes an 8-bit register port with read data one cycle after the strobe.
//
// Behaviour
// - Ninth bit and errors travel with each entry
// - Receive-complete set while unread data exist
// - Receiver disable flushes buffer, clears receive-complete
// - Interrupt request follows receive-complete while enabled
// - Error flags ignore software writes
// - Error flags never raise an interrupt
// - Frame error shows first stop bit low
// - Frame error ignores stop bit count setting
// - Two entries; overrun on full, pending, start
// - Overrun shown after buffered characters read
// - Overrun flag clears on successful transfer
// - Parity check only with upper parity bit
// - Parity error held per character until read
// - Parity flag reads zero when checking off
// - Disable is immediate, drops reception, frees pin
// - Unused upper data bits read zero
// - Frame moves to buffer at first stop
// - Enable starts reception, takes the pin
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module usrbs_receiver
  import usrbs_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic [7:0]      regRdata,
  input  wire logic       rxPin,
  output logic            rxPinOwned,
  output logic            rxIrq
);
  initial if (FIFO_DEPTH != 2) $error("Buffer logic serves exactly two entries");

  // Number of data bits for a character size code
  function automatic logic [3:0] dataBits(input logic [2:0] code);
    if (code == CSIZE_NINE) begin
      return 4'h9;
    end
    return 4'h5 + {2'b00, code[1:0]};
  endfunction

  // Mask that zeroes unused upper bits of the low data byte
  function automatic logic [7:0] lowMask(input logic [2:0] code);
    logic [3:0] n;
    n = dataBits(code);
    return (n >= 4'h8) ? 8'hFF : 8'((9'h001 << n) - 9'h001);
  endfunction

  // Control registers
  logic [7:0] ctrlB_reg, ctrlB_next;       // Enables and ninth bit view
  logic [7:0] ctrlC_reg, ctrlC_next;       // Frame format
  // Buffer storage and pointers
  logic [ENT_W-1:0] mem_reg [FIFO_DEPTH];  // Entries, indexed by pointer
  logic [ENT_W-1:0] memWr;                 // Entry written on a push
  logic       wrPtr_reg, wrPtr_next;       // Next slot to fill
  logic       rdPtr_reg, rdPtr_next;       // Oldest unread slot
  logic [1:0] count_reg, count_next;       // Unread entries
  // Shift register holding stage, waiting for a free slot
  logic [ENT_W-1:0] pend_reg, pend_next;
  logic       pendV_reg, pendV_next;
  logic       ovrMem_reg, ovrMem_next;     // Loss remembered, not yet shown
  logic       drop_reg, drop_next;         // Frame in flight is lost
  // Outputs
  logic [7:0] rdata_next;
  logic       irq_next;
  // Decoded strobes and views
  logic       receiver_enable, irqEn, parEn;
  logic       pop, push, ovrEvent, emptyRead;
  logic       rx_complete_flag, rxcNext;
  logic [ENT_W-1:0] head;
  logic [7:0] statusView;
  // Frame shifter signals
  logic       lineSync, startSeen, frameDone, stopBad, parityBad;
  logic [8:0] frameData;

  // Live control bits; a cleared enable acts in the very next cycle
  assign receiver_enable  = ctrlB_reg[CB_RX_ON];
  assign irqEn = ctrlB_reg[CB_IRQ_EN];
  assign parEn = ctrlC_reg[CC_PAR_EN];

  // Pin is synchronised before the shifter looks at it
  usrbs_sync u_sync (
    .clk     (clk),
    .resetn  (resetn),
    .pinIn   (rxPin),
    .pinSync (lineSync)
  );

  // Shifter is held clear while the receiver is off
  // Size and parity are read live; change them only between frames
  usrbs_frame_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_frame (
    .clk       (clk),
    .resetn    (resetn),
    .clear     (!receiver_enable),
    .rxLine    (lineSync),
    .numBits   (dataBits(ctrlC_reg[CC_CSIZE +: 3])),
    .parityEn  (parEn),
    .parityOdd (ctrlC_reg[CC_PAR_ODD]),
    .startSeen (startSeen),
    .frameDone (frameDone),
    .frameData (frameData),
    .stopBad   (stopBad),
    .parityBad (parityBad)
  );

  // Status view; with the buffer drained a remembered loss still shows
  always_comb begin
    head = mem_reg[rdPtr_reg];
    rx_complete_flag = (count_reg != 2'd0) || ovrMem_reg;
    statusView = 8'h00;
    statusView[ST_RX_DONE] = rx_complete_flag;
    if (count_reg != 2'd0) begin
      statusView[ST_FRM_ERR] = head[ENT_FRM_ERR];
      statusView[ST_OVR]     = head[ENT_OVR];
      // Gated again at read time: a stored error hides once checking is off
      statusView[ST_PAR_ERR] = head[ENT_PAR_ERR] && parEn;
    end else begin
      statusView[ST_OVR] = ovrMem_reg;
    end
  end

  // Buffer, holding stage and overrun tracking. The holding stage stands
  // for the character waiting in the shift register: it sits there until a
  // slot frees, and a new start bit while it waits is the overrun case.
  always_comb begin
    pop = regRd && (regAddr == ADDR_DATA) && (count_reg != 2'd0);
    emptyRead = regRd && (regAddr == ADDR_DATA) && (count_reg == 2'd0);
    push = pendV_reg && (count_reg != 2'd2);
    // Full buffer, a character waiting and a new start bit
    ovrEvent = startSeen && (count_reg == 2'd2) && pendV_reg && !pop;
    memWr = pend_reg;
    memWr[ENT_OVR] = ovrMem_reg;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    pend_next = pend_reg;
    pendV_next = pendV_reg;
    drop_next = drop_reg;
    if (push) begin
      wrPtr_next = !wrPtr_reg;
      pendV_next = 1'b0;
    end
    if (pop) begin
      rdPtr_next = !rdPtr_reg;
    end
    count_next = count_reg + {1'b0, push} - {1'b0, pop};
    if (ovrEvent) begin
      drop_next = 1'b1;
    end
    if (frameDone) begin
      if (drop_reg) begin
        drop_next = 1'b0;
      end else begin
        pendV_next = 1'b1;
        pend_next = {parityBad, 1'b0, stopBad, frameData};
      end
    end
    // Loss is remembered; a new loss wins over its clear
    ovrMem_next = (ovrMem_reg && !push && !emptyRead) || ovrEvent;
    if (!receiver_enable) begin
      // Immediate flush of everything unread
      wrPtr_next = 1'b0;
      rdPtr_next = 1'b0;
      count_next = 2'd0;
      pendV_next = 1'b0;
      drop_next = 1'b0;
      ovrMem_next = 1'b0;
    end
    rxcNext = (count_next != 2'd0) || ovrMem_next;
  end

  // Register writes; status flags have no write path at all, so a
  // write to the status offset can never disturb a stored error bit
  always_comb begin
    ctrlB_next = ctrlB_reg;
    ctrlC_next = ctrlC_reg;
    if (regWr && regAddr == ADDR_CTRL_B) begin
      ctrlB_next = regWdata & 8'h90;
    end
    if (regWr && regAddr == ADDR_CTRL_C) begin
      ctrlC_next = regWdata & 8'h3F;
    end
  end

  // Read data for the cycle after the strobe, interrupt from flag only
  // Interrupt uses next-state values so it drops at the emptying pop
  always_comb begin
    rdata_next = 8'h00;
    if (regRd) begin
      case (regAddr)
        ADDR_STATUS: rdata_next = statusView;
        ADDR_CTRL_B: begin
          rdata_next = ctrlB_reg;
          rdata_next[CB_RX9] = (count_reg != 2'd0) && head[8];
        end
        ADDR_CTRL_C: rdata_next = ctrlC_reg;
        ADDR_DATA: begin
          if (count_reg != 2'd0) begin
            rdata_next = head[7:0] & lowMask(ctrlC_reg[CC_CSIZE +: 3]);
          end
        end
        default: rdata_next = 8'h00;
      endcase
    end
    irq_next = ctrlB_next[CB_IRQ_EN] && rxcNext;
  end

  // Registers only; storage is written on a push, pointers wrap at two
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrlB_reg <= CTRL_B_RST;
      ctrlC_reg <= CTRL_C_RST;
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'd0;
      pend_reg <= '0;
      pendV_reg <= 1'b0;
      ovrMem_reg <= 1'b0;
      drop_reg <= 1'b0;
      regRdata <= 8'h00;
      rxIrq <= 1'b0;
      rxPinOwned <= 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      ctrlB_reg <= ctrlB_next;
      ctrlC_reg <= ctrlC_next;
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      pend_reg <= pend_next;
      pendV_reg <= pendV_next;
      ovrMem_reg <= ovrMem_next;
      drop_reg <= drop_next;
      regRdata <= rdata_next;
      rxIrq <= irq_next;
      rxPinOwned <= ctrlB_next[CB_RX_ON];
      if (push && receiver_enable) begin
        mem_reg[wrPtr_reg] <= memWr;
      end
    end
  end

  // Checks: each guards one rule next to the logic that keeps it
  // Receive-complete as software sees it through a status read
  property p_rxc_set;
    @(posedge clk) disable iff (!resetn)
      (regRd && regAddr == ADDR_STATUS && count_reg != 2'd0) |=> regRdata[ST_RX_DONE];
  endproperty
  a_rxc_set: assert property (p_rxc_set) else $error("Unread data without receive-complete");

  property p_flush;
    @(posedge clk) disable iff (!resetn) !receiver_enable |=> (count_reg == 2'd0) && !ovrMem_reg && !pendV_reg;
  endproperty
  a_flush: assert property (p_flush) else $error("Buffer not flushed while disabled");

  // Request mirrors the flag in the same cycle, with no extra delay
  property p_irq;
    @(posedge clk) disable iff (!resetn) rxIrq == (irqEn && rx_complete_flag);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt does not follow receive-complete");

  // Error bits alone can never hold the request up
  property p_no_err_irq;
    @(posedge clk) disable iff (!resetn) !rx_complete_flag |-> !rxIrq;
  endproperty
  a_no_err_irq: assert property (p_no_err_irq) else $error("Interrupt without receive-complete");

  property p_ro_flags;
    @(posedge clk) disable iff (!resetn)
      (regWr && regAddr == ADDR_STATUS && !regRd && receiver_enable && count_reg != 2'd0) |=> $stable(head) && $stable(rdPtr_reg);
  endproperty
  a_ro_flags: assert property (p_ro_flags) else $error("Status write changed stored flags");

  property p_depth;
    @(posedge clk) disable iff (!resetn) count_reg <= 2'd2;
  endproperty
  a_depth: assert property (p_depth) else $error("Buffer holds more than two entries");

  property p_ovr_mem;
    @(posedge clk) disable iff (!resetn) (ovrEvent && receiver_enable) |=> ovrMem_reg && drop_reg;
  endproperty
  a_ovr_mem: assert property (p_ovr_mem) else $error("Overrun not remembered");

  property p_ovr_clear;
    @(posedge clk) disable iff (!resetn)
      (push && receiver_enable && ovrMem_reg && !ovrEvent) |=> !ovrMem_reg && mem_reg[$past(wrPtr_reg)][ENT_OVR];
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("Overrun not moved into entry");

  property p_upe_off;
    @(posedge clk) disable iff (!resetn) (regRd && regAddr == ADDR_STATUS && !parEn) |=> !regRdata[ST_PAR_ERR];
  endproperty
  a_upe_off: assert property (p_upe_off) else $error("Parity error shown while checking off");

  property p_mask;
    @(posedge clk) disable iff (!resetn)
      (regRd && regAddr == ADDR_DATA && ctrlC_reg[CC_CSIZE +: 3] == 3'h0) |=> regRdata[7:5] == 3'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("Unused data bits not zero");

  // Frame error read back is the head entry's stored frame error bit
  property p_err_view;
    @(posedge clk) disable iff (!resetn)
      (regRd && regAddr == ADDR_STATUS && count_reg != 2'd0) |=> regRdata[ST_FRM_ERR] == $past(head[ENT_FRM_ERR]);
  endproperty
  a_err_view: assert property (p_err_view) else $error("Frame error flag differs from entry");

  // Pin ownership follows the enable bit exactly
  property p_pin_owned;
    @(posedge clk) disable iff (!resetn) rxPinOwned == receiver_enable;
  endproperty
  a_pin_owned: assert property (p_pin_owned) else $error("Pin ownership differs from enable");

  // A kept frame reaches the holding stage one cycle after frameDone, two after its stop bit sample
  property p_stop_to_buf;
    @(posedge clk) disable iff (!resetn) (frameDone && !drop_reg && receiver_enable) |=> pendV_reg;
  endproperty
  a_stop_to_buf: assert property (p_stop_to_buf) else $error("Finished frame not taken");

  // Disable stops the shifter at once; no late start or frame end
  property p_rx_off;
    @(posedge clk) disable iff (!resetn) !receiver_enable |=> !startSeen && !frameDone;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("Shifter active while disabled");

  // Main scenarios the bench is expected to reach
  c_push: cover property (@(posedge clk) disable iff (!resetn) push);
  c_frame_err: cover property (@(posedge clk) disable iff (!resetn) frameDone && stopBad);
  c_full: cover property (@(posedge clk) disable iff (!resetn) count_reg == 2'd2 && pendV_reg);
  c_ovr: cover property (@(posedge clk) disable iff (!resetn) ovrEvent);
  c_pop: cover property (@(posedge clk) disable iff (!resetn) pop ##1 rxIrq);
endmodule
`default_nettype wire

// file: verilog/usrbs_sync.sv
// Two-stage synchroniser for the receive pin.
// Assumes the pin idles high, so both stages reset to one.
`timescale 1ns/1ps
`default_nettype none
module usrbs_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pinIn,
  output logic      pinSync
);
  logic stage1_reg;  // First stage, read only by the second
  logic stage2_reg;  // Second stage, safe to use
  // Both stages sample every clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1_reg <= 1'b1;
      stage2_reg <= 1'b1;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
    end
  end
  assign pinSync = stage2_reg;
endmodule
`default_nettype wire
